// File: tws_slave_rx.sv
// Two-wire slave receiver core with its register port.
// Assumes a master-side block supplies arb_lost and consumes start_gen,
// and a power manager drives sleep while clocks other than idle are off.
// What this block does
// - Answer as slave to the seven-bit own address in bits 7..1.
// - Own-address bit 0 enables answering the general call address 0x00.
// - With acknowledge enable low, never acknowledge own address or call.
// - Direction bit zero selects receive; one selects slave transmit.
// - After own address with write, set service flag and valid status.
// - Acknowledge enable cleared means NACK after the next data byte.
// - In deep sleep, still recognise and acknowledge, running on the system clock clk.
// - After a sleep match, request wake-up and hold SCL till flag cleared.
// - Data register need not hold the last bus byte after sleep wake.
// - Status 0x60 for own address plus write acknowledged.
// - Status 0x68 for own address after lost arbitration.
// - Status 0x70 for general call acknowledged.
// - Status 0x78 for general call after lost arbitration.
// - Status 0x80 for data acknowledged under own address.
// - Status 0x88 for data not acknowledged under own address; then not addressed.
// - Leaving after a NACKed data byte with start request set issues START once bus is free.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module tws_slave_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Bus pins, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // System
    input wire logic sleep,
    input wire logic arb_lost,
    output logic wake_req,
    output logic start_gen,
    output logic irq
);
    tws_line_if ln ();
    tws_pkg::tws_state_e st_q;
    logic flag, ack_en, start_req, stop_req, wcol, en, irq_en;
    logic [7:0] own, data_q, code, irq_st, irq_mask;
    logic gc_q, arb_q, ack_val, ack_on, ack_fell, addr_ack, nack_q;
    logic start_pend, busy;
    logic ctrl_wr, flag_clr, own_hit, gc_hit, ack_end, bus_evt, stop_evt;
    logic set_evt, wake_evt;

    tws_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ln(ln.sync)
    );

    tws_shift u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .ln(ln.shf)
    );

    // Status code for the end of an acknowledge slot
    function automatic logic [7:0] slot_code(input logic adr, input logic gc,
                                             input logic arb,
                                             input logic nack);
        if (adr && gc) begin
            slot_code = arb ? tws_pkg::CODE_ARB_GC : tws_pkg::CODE_GC;
        end else if (adr) begin
            slot_code = arb ? tws_pkg::CODE_ARB_OWN_W : tws_pkg::CODE_OWN_W;
        end else if (gc) begin
            slot_code = nack ? tws_pkg::CODE_GC_NACK : tws_pkg::CODE_GC_ACK;
        end else begin
            slot_code = nack ? tws_pkg::CODE_DATA_NACK
                             : tws_pkg::CODE_DATA_ACK;
        end
    endfunction

    // Decodes and events
    assign ctrl_wr = wr && (addr == tws_pkg::REG_CTRL);
    assign flag_clr = ctrl_wr && wdata[tws_pkg::CTRL_FLAG];
    assign own_hit = (ln.rx_byte[7:1] == own[7:1]) && !ln.rx_byte[0];
    assign gc_hit = (ln.rx_byte == {tws_pkg::GC_ADDR, 1'b0})
        && own[tws_pkg::OWN_GC_EN];
    assign ack_end = (st_q == tws_pkg::ST_ACK) && ln.scl_fall && ack_fell;
    assign bus_evt = ln.start_det || ln.stop_det;
    assign stop_evt = (st_q == tws_pkg::ST_DATA) && bus_evt && en;
    assign set_evt = ack_end || stop_evt;
    assign wake_evt = ack_end && addr_ack && sleep;

    // Control register; flag set wins over a software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag <= tws_pkg::CTRL_RST[tws_pkg::CTRL_FLAG];
            ack_en <= tws_pkg::CTRL_RST[tws_pkg::CTRL_ACK_EN];
            start_req <= tws_pkg::CTRL_RST[tws_pkg::CTRL_START];
            stop_req <= tws_pkg::CTRL_RST[tws_pkg::CTRL_STOP];
            en <= tws_pkg::CTRL_RST[tws_pkg::CTRL_EN];
            irq_en <= tws_pkg::CTRL_RST[tws_pkg::CTRL_IRQ_EN];
        end else begin
            if (set_evt) begin
                flag <= 1'b1;
            end else if (flag_clr) begin
                flag <= 1'b0;
            end
            if (ctrl_wr) begin
                ack_en <= wdata[tws_pkg::CTRL_ACK_EN];
                start_req <= wdata[tws_pkg::CTRL_START];
                stop_req <= wdata[tws_pkg::CTRL_STOP];
                en <= wdata[tws_pkg::CTRL_EN];
                irq_en <= wdata[tws_pkg::CTRL_IRQ_EN];
            end
        end
    end

    // Own address and interrupt mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            own <= tws_pkg::OWN_RST;
            irq_mask <= tws_pkg::MASK_RST;
        end else begin
            if (wr && addr == tws_pkg::REG_OWN) begin
                own <= wdata;
            end
            if (wr && addr == tws_pkg::REG_IRQ_MASK) begin
                irq_mask <= wdata;
            end
        end
    end

    // Data register; a sleeping core does not capture bus bytes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= 8'h00;
            wcol <= 1'b0;
        end else if (st_q == tws_pkg::ST_DATA && ln.byte_done && !sleep) begin
            data_q <= ln.rx_byte;
        end else if (wr && addr == tws_pkg::REG_DATA) begin
            if (flag) begin
                data_q <= wdata;
                wcol <= 1'b0;
            end else begin
                wcol <= 1'b1; // Write while the bus owns the register
            end
        end
    end

    // Lost arbitration is remembered until the address slot reports it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arb_q <= 1'b0;
        end else if (arb_lost) begin
            arb_q <= 1'b1;
        end else if (ack_end && addr_ack) begin
            arb_q <= 1'b0;
        end
    end

    // Bus busy between START and STOP
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (ln.start_det) begin
            busy <= 1'b1;
        end else if (ln.stop_det) begin
            busy <= 1'b0;
        end
    end

    // Receiver sequence
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= tws_pkg::ST_IDLE;
            code <= tws_pkg::CODE_NONE;
            gc_q <= 1'b0;
            ack_val <= 1'b0;
            ack_on <= 1'b0;
            ack_fell <= 1'b0;
            addr_ack <= 1'b0;
            nack_q <= 1'b0;
            start_pend <= 1'b0;
            start_gen <= 1'b0;
        end else begin
            start_gen <= start_pend && !busy;
            if (start_pend && !busy) begin
                start_pend <= 1'b0;
            end
            if (!en) begin
                st_q <= tws_pkg::ST_IDLE;
                ack_on <= 1'b0;
                ack_fell <= 1'b0;
            end else if (bus_evt) begin
                // Address recognition restarts on every START
                st_q <= ln.start_det ? tws_pkg::ST_ADDR : tws_pkg::ST_IDLE;
                ack_on <= 1'b0;
                ack_fell <= 1'b0;
                if (stop_evt) begin
                    code <= tws_pkg::CODE_STOP;
                end
            end else begin
                case (st_q)
                    tws_pkg::ST_ADDR: begin
                        if (ln.byte_done) begin
                            // Read direction belongs to the transmitter
                            if (ack_en && (own_hit || gc_hit)) begin
                                st_q <= tws_pkg::ST_ACK;
                                ack_val <= 1'b1;
                                addr_ack <= 1'b1;
                                gc_q <= gc_hit;
                            end else begin
                                st_q <= tws_pkg::ST_SKIP;
                            end
                        end
                    end
                    tws_pkg::ST_ACK: begin
                        if (ln.scl_fall && !ack_fell) begin
                            ack_fell <= 1'b1;
                            ack_on <= ack_val;
                        end else if (ln.scl_fall) begin
                            ack_on <= 1'b0;
                            ack_fell <= 1'b0;
                            nack_q <= !ack_val;
                            st_q <= tws_pkg::ST_HOLD;
                            code <= slot_code(addr_ack, gc_q, arb_q, !ack_val);
                        end
                    end
                    tws_pkg::ST_HOLD: begin
                        if (flag_clr && !set_evt) begin
                            addr_ack <= 1'b0;
                            if (nack_q) begin
                                st_q <= tws_pkg::ST_IDLE;
                                start_pend <= wdata[tws_pkg::CTRL_START];
                            end else begin
                                st_q <= tws_pkg::ST_DATA;
                            end
                        end
                    end
                    tws_pkg::ST_DATA: begin
                        if (ln.byte_done) begin
                            st_q <= tws_pkg::ST_ACK;
                            ack_val <= ack_en;
                        end
                    end
                    tws_pkg::ST_IDLE, tws_pkg::ST_SKIP: begin
                        st_q <= st_q;
                    end
                    default: begin
                        st_q <= tws_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Pin drivers; SCL stays low while the flag is pending in ST_HOLD
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            sda_oe <= ack_on;
            scl_oe <= flag && (st_q == tws_pkg::ST_HOLD);
            sda_out <= 1'b0; // Open drain only ever pulls low
            scl_out <= 1'b0;
            wake_req <= sleep && flag && (st_q == tws_pkg::ST_HOLD);
        end
    end

    // Sticky interrupt status, cleared by reading it; new events win
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_st <= 8'h00;
            irq <= 1'b0;
        end else begin
            irq_st <= ((rd && addr == tws_pkg::REG_IRQ_ST) ? 8'h00 : irq_st)
                | (8'(set_evt) << tws_pkg::IRQ_SVC)
                | (8'(stop_evt) << tws_pkg::IRQ_STOP)
                | (8'(wake_evt) << tws_pkg::IRQ_WAKE);
            irq <= |(irq_st & irq_mask);
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                tws_pkg::REG_CTRL: rdata <= {flag, ack_en, start_req,
                    stop_req, wcol, en, 1'b0, irq_en};
                // Prescaler field reads zero here
                tws_pkg::REG_STAT: rdata <= {code[7:3], 3'h0};
                tws_pkg::REG_DATA: rdata <= data_q;
                tws_pkg::REG_OWN: rdata <= own;
                tws_pkg::REG_IRQ_ST: rdata <= irq_st;
                tws_pkg::REG_IRQ_MASK: rdata <= irq_mask;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    sequence addr_done_s;
        st_q == tws_pkg::ST_ADDR && ln.byte_done && !bus_evt && en;
    endsequence

    sequence slot_start_s;
        st_q == tws_pkg::ST_ACK && ln.scl_fall && !ack_fell && ack_val
            && !bus_evt && en;
    endsequence

    own_match_a: assert property (@(posedge clk) disable iff (!rst_n)
        addr_done_s and (ack_en && own_hit) |=> st_q == tws_pkg::ST_ACK)
        else $error("own address not taken");
    gc_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        addr_done_s and (!own[0] && ln.rx_byte == 8'h00)
        |=> st_q == tws_pkg::ST_SKIP)
        else $error("general call taken while disabled");
    ack_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        addr_done_s and !ack_en |=> st_q != tws_pkg::ST_ACK)
        else $error("address acked with ack disabled");
    read_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        addr_done_s and ln.rx_byte[0] |=> st_q == tws_pkg::ST_SKIP)
        else $error("read direction entered receiver");
    ack_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        slot_start_s |=> ack_on ##1 sda_oe)
        else $error("ack slot not driven");
    nack_free_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == tws_pkg::ST_ACK && !ack_val) |=> !ack_on)
        else $error("sda driven on nack slot");
    flag_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        ack_end && !bus_evt && en |=> flag && st_q == tws_pkg::ST_HOLD
        ##1 scl_oe)
        else $error("flag or hold missing after slot");
    own_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        ack_end && addr_ack && !gc_q && !arb_q && !bus_evt && en
        |=> code == tws_pkg::CODE_OWN_W)
        else $error("wrong code for own address");
    gc_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        ack_end && addr_ack && gc_q && arb_q && !bus_evt && en
        |=> code == tws_pkg::CODE_ARB_GC)
        else $error("wrong code for lost-arbitration call");
    data_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(flag) && code == tws_pkg::CODE_DATA_ACK && !sleep
        |-> data_q == ln.rx_byte)
        else $error("flag before data load");
    nack_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == tws_pkg::ST_HOLD && nack_q && flag_clr && !set_evt
        && !bus_evt && en |=> st_q == tws_pkg::ST_IDLE)
        else $error("not released after nack");
    start_free_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_gen |-> $past(start_pend) && !$past(busy))
        else $error("start issued on busy bus");
endmodule // tws_slave_rx

// File: tws_pkg.sv
// Constants for the two-wire slave receiver.
// Assumes one 50 MHz system clock and an 8-bit register port.
package tws_pkg;
    // Register offsets on the 3-bit register port
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_OWN = 3'h3;
    localparam logic [2:0] REG_IRQ_ST = 3'h4;
    localparam logic [2:0] REG_IRQ_MASK = 3'h5;
    // Control register bit positions
    localparam int CTRL_FLAG = 7;
    localparam int CTRL_ACK_EN = 6;
    localparam int CTRL_START = 5;
    localparam int CTRL_STOP = 4;
    localparam int CTRL_WCOL = 3;
    localparam int CTRL_EN = 2;
    localparam int CTRL_IRQ_EN = 0;
    // Own-address register: general call enable is bit 0
    localparam int OWN_GC_EN = 0;
    // Interrupt status and mask bit positions
    localparam int IRQ_SVC = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_WAKE = 2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CODE_NONE = 8'hff;
    // Address byte of a general call
    localparam logic [6:0] GC_ADDR = 7'h00;
    // Bits per byte before the acknowledge slot
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Status codes
    localparam logic [7:0] CODE_OWN_W = 8'h60;
    localparam logic [7:0] CODE_ARB_OWN_W = 8'h68;
    localparam logic [7:0] CODE_GC = 8'h70;
    localparam logic [7:0] CODE_ARB_GC = 8'h78;
    localparam logic [7:0] CODE_DATA_ACK = 8'h80;
    localparam logic [7:0] CODE_DATA_NACK = 8'h88;
    localparam logic [7:0] CODE_GC_ACK = 8'h90;
    localparam logic [7:0] CODE_GC_NACK = 8'h98;
    localparam logic [7:0] CODE_STOP = 8'ha0;
    // Receiver states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_HOLD = 3'b011,
        ST_DATA = 3'b100,
        ST_SKIP = 3'b101
    } tws_state_e;
endpackage

// File: tws_line_if.sv
// Bus-line events shared by the synchroniser, shifter and core.
// Assumes all three run on the same system clock.
interface tws_line_if;
    logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
    logic [7:0] rx_byte;
    logic byte_done;
    modport sync (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport shf (input sda, scl_rise, start_det, stop_det,
                 output rx_byte, byte_done);
    modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det,
                  input rx_byte, byte_done);
endinterface

// File: tws_sync.sv
// Pin synchroniser and bus condition detector.
// Assumes SCL and SDA come straight from pads, unrelated to clk.
module tws_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pads
    input wire logic scl_in,
    input wire logic sda_in,
    // Events
    tws_line_if.sync ln
);
    logic [1:0] s1, s2, s3, lvl, next_lvl;

    // Three stages; bit 1 is SCL, bit 0 is SDA
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= 2'h3;
            s2 <= 2'h3;
            s3 <= 2'h3;
        end else begin
            s1 <= {scl_in, sda_in};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A level only moves once stages two and three agree
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
        end
    end

    // Edges and conditions from the filtered levels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lvl <= 2'h3;
            ln.scl <= 1'b1;
            ln.sda <= 1'b1;
            ln.scl_rise <= 1'b0;
            ln.scl_fall <= 1'b0;
            ln.start_det <= 1'b0;
            ln.stop_det <= 1'b0;
        end else begin
            lvl <= next_lvl;
            ln.scl <= next_lvl[1];
            ln.sda <= next_lvl[0];
            ln.scl_rise <= !lvl[1] && next_lvl[1];
            ln.scl_fall <= lvl[1] && !next_lvl[1];
            ln.start_det <= lvl[1] && next_lvl[1] && lvl[0] && !next_lvl[0];
            ln.stop_det <= lvl[1] && next_lvl[1] && !lvl[0] && next_lvl[0];
        end
    end

    filter_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s2[1] == s3[1]) |=> (lvl[1] == $past(s3[1])))
        else $error("scl level ignored agreeing stages");
endmodule // tws_sync

// File: tws_shift.sv
// Bit counter and receive shift register.
// Assumes filtered line events from the synchroniser.
module tws_shift (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line
    tws_line_if.shf ln
);
    logic [3:0] cnt;

    // Eight data bits, then the acknowledge slot wraps the count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            ln.rx_byte <= 8'h00;
            ln.byte_done <= 1'b0;
        end else begin
            ln.byte_done <= ln.scl_rise && (cnt == tws_pkg::BYTE_BITS - 4'h1);
            if (ln.start_det || ln.stop_det) begin
                cnt <= 4'h0;
            end else if (ln.scl_rise) begin
                cnt <= (cnt == tws_pkg::BYTE_BITS) ? 4'h0 : cnt + 4'h1;
                if (cnt != tws_pkg::BYTE_BITS) begin
                    ln.rx_byte <= {ln.rx_byte[6:0], ln.sda}; // MSB first
                end
            end
        end
    end

    byte_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        ln.byte_done |-> (cnt == tws_pkg::BYTE_BITS))
        else $error("byte done off the eighth bit");
endmodule // tws_shift

// File: tws_bfm.sv
// Bus master transmitter model for the slave receiver bench.
// Assumes the bench resolves both open-drain lines with pull-ups.
module tws_bfm (
    // Resolved lines
    input wire logic scl,
    input wire logic sda,
    // Drives, low pulls the line
    output logic scl_d,
    output logic sda_d
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_d = 1'b1;
        sda_d = 1'b1;
    end
    // SDA falls while SCL is high
    task automatic start();
        sda_d = 1'b0;
        #40 scl_d = 1'b0;
        #40;
    endtask
    // SDA moves only with SCL low; a stretched SCL is waited out
    task automatic bit_io(input logic b, output logic seen);
        sda_d = b;
        #40 scl_d = 1'b1;
        wait (scl === 1'b1);
        #80 seen = sda; // Late sample: slave answers through a filter
        scl_d = 1'b0;
        #40;
    endtask
    // Eight bits MSB first, then SDA released for the answer
    task automatic send(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], s);
        end
        #80; // Slave answers through its pin filter; SDA must settle first
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // SDA rises while SCL is high
    task automatic stop();
        sda_d = 1'b0;
        #40 scl_d = 1'b1;
        wait (scl === 1'b1);
        #40 sda_d = 1'b1;
        #160;
    endtask
endmodule // tws_bfm

// File: tws_tb.sv
// Self-checking bench for the slave receiver core.
// Assumes tws_bfm as bus master and a 50 MHz system clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic arb = 1'b0;
    logic sg_seen = 1'b0;
    logic [7:0] rdata;
    logic scl_out, scl_oe, sda_out, sda_oe, wake_req, start_gen, irq;
    logic scl_d, sda_d;
    wire scl;
    wire sda;
    int failures = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    // Open-drain resolve with pull-ups
    assign scl = scl_d & (~scl_oe | scl_out);
    assign sda = sda_d & (~sda_oe | sda_out);
    // Start requests are pulses; keep a sticky copy
    always @(posedge clk) if (start_gen === 1'b1) sg_seen <= 1'b1;
    tws_slave_rx uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .sleep(sleep), .arb_lost(arb), .wake_req(wake_req),
        .start_gen(start_gen), .irq(irq));
    tws_bfm m (.scl(scl), .sda(sda), .scl_d(scl_d), .sda_d(sda_d));
    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string n, logic [2:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask
    // One byte, its answer, then the status once the flag has landed
    task automatic xfer(input logic [7:0] b, logic ea, logic [7:0] code);
        logic ack;
        m.send(b, ack);
        chk("ack", {7'h00, ea}, {7'h00, ack});
        repeat (8) @(posedge clk);
        if (code != 8'h00) rchk("status", tws_pkg::REG_STAT, code);
    endtask
    // Stop, then clear any flag the stop raised
    task automatic fin();
        m.stop();
        repeat (10) @(posedge clk);
        put(tws_pkg::REG_CTRL, 8'hc4);
    endtask
    task automatic pulse_arb();
        @(posedge clk) arb <= 1'b1;
        @(posedge clk) arb <= 1'b0;
    endtask
    task automatic t_reset();
        rchk("ctrl", tws_pkg::REG_CTRL, tws_pkg::CTRL_RST);
        rchk("stat", tws_pkg::REG_STAT, tws_pkg::CODE_NONE & 8'hf8);
        rchk("own", tws_pkg::REG_OWN, tws_pkg::OWN_RST);
        rchk("mask", tws_pkg::REG_IRQ_MASK, tws_pkg::MASK_RST);
        rchk("unmapped", 3'h6, 8'h00);
    endtask
    task automatic t_own();
        put(tws_pkg::REG_OWN, 8'ha0);
        put(tws_pkg::REG_IRQ_MASK, 8'h01);
        put(tws_pkg::REG_CTRL, 8'h44);
        m.start();
        xfer(8'ha0, 1'b1, tws_pkg::CODE_OWN_W);
        chk("hold", 8'h01, {7'h00, scl_oe});
        chk("irq", 8'h01, {7'h00, irq});
        rchk("irq_st", tws_pkg::REG_IRQ_ST, 8'h01);
        put(tws_pkg::REG_CTRL, 8'hc4);
        xfer(8'h3c, 1'b1, tws_pkg::CODE_DATA_ACK);
        rchk("data", tws_pkg::REG_DATA, 8'h3c);
        put(tws_pkg::REG_CTRL, 8'h84);
        xfer(8'h5a, 1'b0, tws_pkg::CODE_DATA_NACK);
        sg_seen = 1'b0;
        put(tws_pkg::REG_CTRL, 8'he4);
        m.stop();
        repeat (20) @(posedge clk);
        chk("start_gen", 8'h01, {7'h00, sg_seen});
        put(tws_pkg::REG_CTRL, 8'hc4);
    endtask
    task automatic t_addr();
        m.start();
        xfer(8'ha2, 1'b0, 8'h00);
        m.stop();
        m.start();
        xfer(8'h00, 1'b0, 8'h00);
        m.stop();
        put(tws_pkg::REG_OWN, 8'ha1);
        m.start();
        xfer(8'h00, 1'b1, tws_pkg::CODE_GC);
        put(tws_pkg::REG_CTRL, 8'hc4);
        fin();
        put(tws_pkg::REG_CTRL, 8'h84);
        m.start();
        xfer(8'ha0, 1'b0, 8'h00);
        m.stop();
        put(tws_pkg::REG_CTRL, 8'hc4);
        m.start();
        xfer(8'ha0, 1'b1, tws_pkg::CODE_OWN_W);
        put(tws_pkg::REG_CTRL, 8'hc4);
        fin();
    endtask
    task automatic t_arb_sleep();
        m.start();
        pulse_arb();
        xfer(8'ha0, 1'b1, tws_pkg::CODE_ARB_OWN_W);
        put(tws_pkg::REG_CTRL, 8'hc4);
        fin();
        m.start();
        pulse_arb();
        xfer(8'h00, 1'b1, tws_pkg::CODE_ARB_GC);
        put(tws_pkg::REG_CTRL, 8'hc4);
        fin();
        // Data register is not compared after wake-up
        @(posedge clk) sleep <= 1'b1;
        m.start();
        xfer(8'ha0, 1'b1, 8'h00);
        chk("wake", 8'h01, {7'h00, wake_req});
        chk("hold", 8'h01, {7'h00, scl_oe});
        @(posedge clk) sleep <= 1'b0;
        put(tws_pkg::REG_CTRL, 8'hc4);
        repeat (3) @(posedge clk);
        chk("hold", 8'h00, {7'h00, scl_oe});
        fin();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_own();
        t_addr();
        t_arb_sleep();
        test_done();
    end
    // Eleven bytes at under two microseconds each; ample margin
    initial begin
        #300us;
        failures++;
        test_done();
    end
endmodule // testbench
